// *** core/alu_core.sv ***
// adder and and unit with the condition flag logic
`timescale 1ns/1ns
module alu_core (
  input  wire alu_pkg::op_t     op,
  input  wire logic             word,
  input  wire logic             status_tgt,
  input  wire logic [15:0]      a_val,
  input  wire logic [15:0]      b_val,
  input  wire alu_pkg::flags_t  flags_in,
  output alu_pkg::alu_out_t     result
);
  import alu_pkg::*;

  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic [15:0] raw;
  logic        res_msb;
  logic        a_msb;
  logic        b_msb;
  logic        zero;

  assign sum_w = {1'b0, a_val} + {1'b0, b_val} + {16'h0000, flags_in.c};
  assign sum_b = {1'b0, a_val[7:0]} + {1'b0, b_val[7:0]} + {8'h00, flags_in.c};

  always_comb begin
    if (op == OP_CARRY_ADD) begin
      raw = word ? sum_w[15:0] : {8'h00, sum_b[7:0]};
    end else begin
      raw = a_val & b_val;
    end
    // byte forms leave the upper byte of the destination alone
    result.value = word ? raw : {a_val[15:8], raw[7:0]};
    res_msb      = word ? raw[15] : raw[7];
    a_msb        = word ? a_val[15] : a_val[7];
    b_msb        = word ? b_val[15] : b_val[7];
    zero         = word ? (raw == 16'h0000) : (raw[7:0] == 8'h00);
    result.flags.n = res_msb;
    result.flags.z = zero;
    result.flags.v = 1'b0;
    result.flags.c = flags_in.c;
    case (op)
      OP_CARRY_ADD: begin
        result.flags.n = res_msb;
        result.flags.z = flags_in.z & zero;
        result.flags.v = (a_msb == b_msb) && (res_msb != a_msb);
        result.flags.c = word ? sum_w[16] : sum_b[8];
      end
      OP_CTRL_AND: begin
        if (status_tgt) begin
          result.flags = flags_t'(raw[FLAGS_LSB +: 4]);
        end
      end
      default: begin
      end
    endcase
  end

endmodule : alu_core

// *** core/alu_pkg.sv ***
// constants and types shared by the carry add and logic unit
package alu_pkg;

  // register byte offsets on the bus
  localparam logic [7:0]  ADDR_INSTR     = 8'h00;
  localparam logic [7:0]  ADDR_SRC       = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;
  localparam logic [7:0]  ADDR_SR        = 8'h0C;
  localparam logic [7:0]  ADDR_PAGE      = 8'h10;
  localparam logic [7:0]  ADDR_GREG_BASE = 8'h20;

  // opcode patterns
  localparam logic [7:0]  PFX_CTRL_BYTE  = 8'h04;
  localparam logic [7:0]  PFX_CTRL_WORD  = 8'h0C;
  localparam logic [4:0]  OPC_CTRL_AND   = 5'h0B;
  localparam logic [4:0]  OPC_CARRY_ADD  = 5'h14;
  localparam logic [4:0]  OPC_REG_AND    = 5'h0A;
  localparam int          SIZE_BIT       = 3;

  // control register selector codes
  localparam logic [2:0]  CSEL_SR        = 3'h0;
  localparam logic [2:0]  CSEL_CCR       = 3'h1;
  localparam logic [2:0]  CSEL_BR        = 3'h3;
  localparam logic [2:0]  CSEL_TP        = 3'h6;

  // flag positions in the status word; C, V, Z and N also in the status register
  localparam int          FLAGS_LSB      = 0;
  localparam int          C_BIT          = 0;
  localparam int          V_BIT          = 1;
  localparam int          Z_BIT          = 2;
  localparam int          N_BIT          = 3;
  localparam int          ILLEGAL_BIT    = 4;
  localparam int          INHIBIT_BIT    = 5;

  // reset values
  localparam logic [15:0] SR_RST         = 16'h0700;
  localparam logic [7:0]  PAGE_RST       = 8'h00;
  localparam logic [15:0] GREG_RST       = 16'h0000;

  typedef enum logic [1:0] {
    OP_NONE       = 2'h0,
    OP_CARRY_ADD  = 2'h1,
    OP_REG_AND    = 2'h2,
    OP_CTRL_AND   = 2'h3
  } op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_t;

  typedef struct packed {
    op_t         op;
    logic        word;
    logic [2:0]  rsel;
    logic [2:0]  csel;
    logic [15:0] imm;
    logic        illegal;
  } decoded_t;

  typedef struct packed {
    logic [15:0] value;
    flags_t      flags;
  } alu_out_t;

endpackage : alu_pkg

// *** core/carry_add_and_logic_unit.sv ***
// execution datapath for carry add, register and and control register and
//
// Overview of operation
// - carry add sums destination, source and carry
// - carry add sets negative from result sign
// - carry add keeps zero only if already zero
// - carry add sets overflow on signed overflow
// - carry add sets carry from top bit
// - register and stores source and destination
// - register and copies result top bit to negative
// - register and sets zero on zero result
// - register and clears overflow, keeps carry
// - control and writes register and immediate back
// - status targets take flags from result bits
// - page targets: negative and zero from result, overflow cleared, carry kept
// - target register fixes byte or word width
// - no interrupt or trace right after control and
// - decode byte and word control and forms
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module carry_add_and_logic_unit (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output      logic [31:0]      HRDATA,
  output      logic             HREADYOUT,
  output      logic             HRESP,
  output      logic             NO_INT_TRACE
);
  import alu_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_READ  = 4'b0100,
    ST_RDATA = 4'b1000
  } state_t;

  function automatic logic is_greg(input logic [7:0] a);
    return a[7:5] == ADDR_GREG_BASE[7:5];
  endfunction : is_greg

  function automatic logic [1:0] page_idx(input logic [2:0] sel);
    return 2'(sel - CSEL_BR);
  endfunction : page_idx

  state_t      state_q;
  state_t      state_d;
  logic        dph_valid_q;
  logic        dph_write_q;
  logic [7:0]  dph_addr_q;
  logic [31:0] instr_q;
  logic [15:0] src_q;
  logic [15:0] sr_q;
  logic [7:0]  page_q [4];
  logic [15:0] greg_q [8];
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic        illegal_q;
  logic        inhibit_q;
  logic        accept;
  logic        ready;
  logic        commit;
  logic        run;
  logic        is_ctrl;
  logic        status_tgt;
  logic [15:0] ctrl_val;
  logic [15:0] a_op;
  logic [15:0] b_op;
  decoded_t    dec;
  alu_out_t    alu;

  instr_decode u_decode (
    .instr (instr_q),
    .dec   (dec)
  );

  assign is_ctrl    = dec.op == OP_CTRL_AND;
  assign status_tgt = dec.csel == CSEL_SR || dec.csel == CSEL_CCR;
  assign ctrl_val   = status_tgt ? sr_q : {8'h00, page_q[page_idx(dec.csel)]};
  // source arrives already fetched, whatever its addressing mode
  assign a_op       = is_ctrl ? ctrl_val : greg_q[dec.rsel];
  assign b_op       = is_ctrl ? dec.imm : src_q;

  alu_core u_alu (
    .op         (dec.op),
    .word       (dec.word),
    .status_tgt (status_tgt),
    .a_val      (a_op),
    .b_val      (b_op),
    .flags_in   (flags_t'(sr_q[FLAGS_LSB +: 4])),
    .result     (alu)
  );

  // bus handshake; one slave so HREADY mirrors HREADYOUT
  assign ready     = state_q == ST_IDLE || state_q == ST_RDATA;
  assign accept    = HSEL && HTRANS[1] && HREADY;
  assign commit    = ready && dph_valid_q && dph_write_q;
  assign run       = state_q == ST_EXEC && !dec.illegal;
  assign HREADYOUT = ready;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_q;
  assign NO_INT_TRACE = inhibit_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q  <= 8'h00;
    end else if (ready) begin
      dph_valid_q <= accept;
      dph_write_q <= HWRITE;
      dph_addr_q  <= HADDR[7:0];
    end
  end

  // execution stalls the bus for one cycle so no write races the writeback
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE, ST_RDATA: begin
        if (commit && dph_addr_q == ADDR_INSTR) begin
          state_d = ST_EXEC;
        end else if (accept && !HWRITE) begin
          state_d = ST_READ;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_EXEC: state_d = (dph_valid_q && !dph_write_q) ? ST_READ : ST_IDLE;
      ST_READ: state_d = ST_RDATA;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_greg(dph_addr_q)) begin
      rd_mux = {16'h0000, greg_q[dph_addr_q[4:2]]};
    end else begin
      case (dph_addr_q)
        ADDR_INSTR:  rd_mux = instr_q;
        ADDR_SRC:    rd_mux = {16'h0000, src_q};
        ADDR_STATUS: rd_mux = {26'h0, inhibit_q, illegal_q, sr_q[FLAGS_LSB +: 4]};
        ADDR_SR:     rd_mux = {16'h0000, sr_q};
        ADDR_PAGE:   rd_mux = {page_q[3], page_q[2], page_q[1], page_q[0]};
        default:     rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hrdata_q <= 32'h0000_0000;
    end else if (state_q == ST_READ) begin
      hrdata_q <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      instr_q <= 32'h0000_0000;
      src_q   <= 16'h0000;
    end else if (commit && dph_addr_q == ADDR_INSTR) begin
      instr_q <= HWDATA;
    end else if (commit && dph_addr_q == ADDR_SRC) begin
      src_q <= HWDATA[15:0];
    end
  end

  generate
    for (genvar i = 0; i < 8; i++) begin : g_greg
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          greg_q[i] <= GREG_RST;
        end else if (commit && is_greg(dph_addr_q) && dph_addr_q[4:2] == 3'(i)) begin
          greg_q[i] <= HWDATA[15:0];
        end else if (run && !is_ctrl && dec.rsel == 3'(i)) begin
          greg_q[i] <= alu.value;
        end
      end
    end
    for (genvar p = 0; p < 4; p++) begin : g_page
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          page_q[p] <= PAGE_RST;
        end else if (commit && dph_addr_q == ADDR_PAGE) begin
          page_q[p] <= HWDATA[8*p +: 8];
        end else if (run && is_ctrl && !status_tgt && page_idx(dec.csel) == 2'(p)) begin
          page_q[p] <= alu.value[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sr_q <= SR_RST;
    end else if (commit && dph_addr_q == ADDR_SR) begin
      sr_q <= HWDATA[15:0];
    end else if (run && is_ctrl && status_tgt) begin
      sr_q <= alu.value;
    end else if (run) begin
      sr_q[FLAGS_LSB +: 4] <= alu.flags;
    end
  end

  // inhibit lasts until the next instruction finishes executing
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      inhibit_q <= 1'b0;
      illegal_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      inhibit_q <= run && is_ctrl;
      illegal_q <= dec.illegal;
    end
  end

  // checks
  logic [16:0] chk_sum;
  logic        add_w;
  logic [15:0] and_w;
  assign chk_sum = {1'b0, greg_q[dec.rsel]} + {1'b0, src_q} + {16'h0000, sr_q[C_BIT]};
  assign and_w   = greg_q[dec.rsel] & src_q;
  assign add_w   = run && dec.op == OP_CARRY_ADD && dec.word;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  a_carry_sum: assert property (
    add_w |=> greg_q[$past(dec.rsel)] == $past(chk_sum[15:0]))
    else $error("carry add result wrong");
  a_add_sign: assert property (
    add_w |=> sr_q[N_BIT] == $past(chk_sum[15]))
    else $error("carry add negative flag wrong");
  a_sticky_zero: assert property (
    run && dec.op == OP_CARRY_ADD |=> !sr_q[Z_BIT] || $past(sr_q[Z_BIT]))
    else $error("zero flag set without prior zero");
  a_carry_out: assert property (
    add_w |=> sr_q[C_BIT] == $past(chk_sum[16]))
    else $error("carry flag wrong");
  a_and_result: assert property (
    run && dec.op == OP_REG_AND && dec.word
      |=> greg_q[$past(dec.rsel)] == $past(greg_q[dec.rsel] & src_q))
    else $error("register and result wrong");
  a_and_flags: assert property (
    run && dec.op == OP_REG_AND |=> !sr_q[V_BIT] && sr_q[C_BIT] == $past(sr_q[C_BIT]))
    else $error("register and overflow or carry wrong");
  a_byte_upper: assert property (
    run && !is_ctrl && !dec.word
      |=> greg_q[$past(dec.rsel)][15:8] == $past(greg_q[dec.rsel][15:8]))
    else $error("byte op disturbed upper byte");
  a_status_flags: assert property (
    run && is_ctrl && status_tgt
      |=> sr_q[FLAGS_LSB +: 4] == $past(sr_q[FLAGS_LSB +: 4] & dec.imm[FLAGS_LSB +: 4]))
    else $error("status flags not taken from result");
  a_page_and: assert property (
    run && is_ctrl && !status_tgt
      |=> page_q[$past(page_idx(dec.csel))] == $past(ctrl_val[7:0] & dec.imm[7:0]))
    else $error("page register and wrong");
  a_page_flags: assert property (
    run && is_ctrl && !status_tgt |=> !sr_q[V_BIT] && sr_q[C_BIT] == $past(sr_q[C_BIT]))
    else $error("page target flags wrong");
  a_width_check: assert property (
    state_q == ST_EXEC && is_ctrl && dec.word != (dec.csel == CSEL_SR) |-> dec.illegal)
    else $error("control and width not fixed by target");
  a_ctrl_decode: assert property (
    instr_q[31:24] == PFX_CTRL_BYTE && instr_q[15:11] == OPC_CTRL_AND |-> is_ctrl && !dec.word)
    else $error("byte control and not decoded");
  a_inhibit_set: assert property (
    run && is_ctrl |=> NO_INT_TRACE ##1 NO_INT_TRACE)
    else $error("inhibit not raised after control and");
  a_inhibit_hold: assert property (
    NO_INT_TRACE && state_q != ST_EXEC |=> NO_INT_TRACE)
    else $error("inhibit dropped before next instruction");
  a_inhibit_clear: assert property (
    state_q == ST_EXEC && !(run && is_ctrl) |=> !NO_INT_TRACE)
    else $error("inhibit kept after other instruction");
  a_add_ovf: assert property (
    add_w |=> sr_q[V_BIT] == $past((greg_q[dec.rsel][15] == src_q[15]) && (chk_sum[15] != src_q[15])))
    else $error("carry add overflow flag wrong");
  a_byte_add: assert property (
    run && dec.op == OP_CARRY_ADD && !dec.word
      |=> greg_q[$past(dec.rsel)][7:0] == $past(greg_q[dec.rsel][7:0] + src_q[7:0] + {7'h00, sr_q[C_BIT]}))
    else $error("byte carry add result wrong");
  a_and_neg: assert property (
    run && dec.op == OP_REG_AND && dec.word |=> sr_q[N_BIT] == $past(and_w[15]))
    else $error("register and negative flag wrong");
  a_and_zero: assert property (
    run && dec.op == OP_REG_AND && dec.word |=> sr_q[Z_BIT] == $past(and_w == 16'h0000))
    else $error("register and zero flag wrong");
  // byte forms must judge flags on the low byte only
  a_byte_neg: assert property (
    run && dec.op == OP_REG_AND && !dec.word |=> sr_q[N_BIT] == $past(and_w[7]))
    else $error("byte and negative flag wrong");
  a_byte_zero: assert property (
    run && dec.op == OP_REG_AND && !dec.word |=> sr_q[Z_BIT] == $past(and_w[7:0] == 8'h00))
    else $error("byte and zero flag wrong");
  a_page_neg: assert property (
    run && is_ctrl && !status_tgt |=> sr_q[N_BIT] == $past(ctrl_val[7] & dec.imm[7]))
    else $error("page target negative flag wrong");
  a_page_zero: assert property (
    run && is_ctrl && !status_tgt |=> sr_q[Z_BIT] == $past((ctrl_val[7:0] & dec.imm[7:0]) == 8'h00))
    else $error("page target zero flag wrong");
  a_illegal_quiet: assert property (
    state_q == ST_EXEC && dec.illegal |=> $stable(sr_q) && !NO_INT_TRACE)
    else $error("illegal instruction changed state");
  // bus must stall while the writeback happens
  a_exec_stall: assert property (
    state_q == ST_EXEC |-> !HREADYOUT)
    else $error("bus ready during execution");
  a_read_wait: assert property (
    state_q == ST_READ |=> HREADYOUT)
    else $error("read data phase not ended");

  c_carry_add: cover property (add_w ##1 sr_q[C_BIT]);
  c_ctrl_status: cover property (run && is_ctrl && status_tgt);
  c_ctrl_page: cover property (run && is_ctrl && !status_tgt);
  c_read_back: cover property (state_q == ST_READ ##1 state_q == ST_RDATA);
  c_illegal: cover property (state_q == ST_EXEC && dec.illegal);

endmodule : carry_add_and_logic_unit

// *** core/instr_decode.sv ***
// decoder of the carry add, register and and control register and forms
`timescale 1ns/1ns
module instr_decode (
  input  wire logic [31:0]      instr,
  output alu_pkg::decoded_t     dec
);
  import alu_pkg::*;

  function automatic logic ctrl_valid(input logic [2:0] sel);
    return sel == CSEL_SR || sel == CSEL_CCR || (sel >= CSEL_BR && sel <= CSEL_TP);
  endfunction : ctrl_valid

  // only the status word is word sized
  function automatic logic ctrl_is_word(input logic [2:0] sel);
    return sel == CSEL_SR;
  endfunction : ctrl_is_word

  always_comb begin
    dec = '0;
    dec.op = OP_NONE;
    if (instr[31:24] == PFX_CTRL_BYTE && instr[15:11] == OPC_CTRL_AND) begin
      dec.op      = OP_CTRL_AND;
      dec.word    = 1'b0;
      dec.csel    = instr[10:8];
      dec.imm     = {8'h00, instr[23:16]};
      dec.illegal = !ctrl_valid(instr[10:8]) || ctrl_is_word(instr[10:8]);
    end else if (instr[31:24] == PFX_CTRL_WORD && instr[7:3] == OPC_CTRL_AND) begin
      dec.op      = OP_CTRL_AND;
      dec.word    = 1'b1;
      dec.csel    = instr[2:0];
      dec.imm     = instr[23:8];
      dec.illegal = !ctrl_valid(instr[2:0]) || !ctrl_is_word(instr[2:0]);
    end else if (instr[23:19] == OPC_CARRY_ADD) begin
      dec.op      = OP_CARRY_ADD;
      dec.word    = instr[24 + SIZE_BIT];
      dec.rsel    = instr[18:16];
    end else if (instr[23:19] == OPC_REG_AND) begin
      dec.op      = OP_REG_AND;
      dec.word    = instr[24 + SIZE_BIT];
      dec.rsel    = instr[18:16];
    end else begin
      dec.illegal = 1'b1;
    end
  end

endmodule : instr_decode

// *** sim/bus_master_model.sv ***
// bus master standing in for the decoder and operand fetch side
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output      logic        hsel,
  output      logic [31:0] haddr,
  output      logic [1:0]  htrans,
  output      logic        hwrite,
  output      logic [2:0]  hsize,
  output      logic [31:0] hwdata
);
  initial begin
    hsel   = 1'b1;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // address phase held until hready is seen high at an edge
  task automatic addr_phase(input logic [7:0] addr, input logic wr);
    @(posedge clk);
    htrans <= 2'h2;
    haddr  <= {24'h0, addr};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : addr_phase

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    addr_phase(addr, 1'b1);
    htrans <= 2'h0;
    haddr  <= ~{24'h0, addr};
    hwdata <= data;
    do @(posedge clk); while (hready !== 1'b1);
    // stale write data would hide a late capture
    hwdata <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    addr_phase(addr, 1'b0);
    htrans <= 2'h0;
    haddr  <= ~{24'h0, addr};
    do @(posedge clk); while (hready !== 1'b1);
    data = hrdata;
  endtask : rd
endmodule : bus_master_model

// *** sim/carry_add_and_logic_unit_tb_top.sv ***
// self-checking bench for the carry add and logic unit
`timescale 1ns/1ns
module carry_add_and_logic_unit_tb_top;
  import alu_pkg::*;
  typedef struct packed {
    logic [31:0] instr;
    logic [15:0] src;
    logic [15:0] rd_in;
    logic [15:0] sr_in;
    logic [7:0]  chk;
    logic [31:0] exp_val;
    logic [3:0]  flags;
  } row_t;
  localparam logic [31:0] PAGE_INIT = 32'hC3A5_5A3C;
  localparam logic [7:0]  R2        = 8'h28;
  localparam int          CEIL      = 6000;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic        no_int_trace;
  logic        nit;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          failures;
  int          compares;
  int          cycles;
  // carry add and register and on R2, then every control register target
  row_t rows [14] = '{
    '{32'hA8A2_0000, 16'h0000, 16'h7FFF, 16'h0701, R2, 32'h0000_8000, 4'hA},
    '{32'hA8A2_0000, 16'h0000, 16'hFFFF, 16'h0705, R2, 32'h0000_0000, 4'h5},
    '{32'hA8A2_0000, 16'h0001, 16'hFFFF, 16'h0700, R2, 32'h0000_0000, 4'h1},
    '{32'hA0A2_0000, 16'h0001, 16'h12FF, 16'h0704, R2, 32'h0000_1200, 4'h5},
    '{32'hA0A2_0000, 16'h0080, 16'h0080, 16'h0701, R2, 32'h0000_0001, 4'h3},
    '{32'hA852_0000, 16'hFF00, 16'hF0F0, 16'h070F, R2, 32'h0000_F000, 4'h9},
    '{32'hA852_0000, 16'hFF00, 16'h00FF, 16'h0700, R2, 32'h0000_0000, 4'h4},
    '{32'hA052_0000, 16'hFFFF, 16'h0B80, 16'h0703, R2, 32'h0000_0B80, 4'h9},
    '{32'h0CF8_FA58, 16'h0000, 16'h0000, 16'h070F, ADDR_SR, 32'h0000_000A, 4'hA},
    '{32'h04F5_5900, 16'h0000, 16'h0000, 16'h070F, ADDR_SR, 32'h0000_0705, 4'h5},
    '{32'h040F_5B00, 16'h0000, 16'h0000, 16'h0705, ADDR_PAGE, 32'hC3A5_5A0C, 4'h1},
    '{32'h0480_5E00, 16'h0000, 16'h0000, 16'h0700, ADDR_PAGE, 32'h80A5_5A3C, 4'h8},
    '{32'h04A5_5C00, 16'h0000, 16'h0000, 16'h070B, ADDR_PAGE, 32'hC3A5_003C, 4'h5},
    '{32'h04FF_5D00, 16'h0000, 16'h0000, 16'h0700, ADDR_PAGE, 32'hC3A5_5A3C, 4'h8}
  };
  // bad selector, status word in byte form, stack page in word form
  logic [31:0] bad [3] = '{32'h0400_5A00, 32'h0400_5800, 32'h0C00_005E};

  carry_add_and_logic_unit dut_u (
    .CLK          (clk),
    .RST_N        (rst_n),
    .HSEL         (hsel),
    .HADDR        (haddr),
    .HTRANS       (htrans),
    .HWRITE       (hwrite),
    .HSIZE        (hsize),
    .HWDATA       (hwdata),
    .HREADY       (hreadyout),
    .HRDATA       (hrdata),
    .HREADYOUT    (hreadyout),
    .HRESP        (hresp),
    .NO_INT_TRACE (no_int_trace)
  );

  bus_master_model bfm_u (
    .clk    (clk),
    .hready (hreadyout),
    .hrdata (hrdata),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hwdata (hwdata)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      failures++;
      conclude();
    end
  end

  initial begin
    rst_n    = 1'b0;
    failures = 0;
    compares = 0;
    cycles   = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bfm_u.rd(ADDR_SR, rdata);
    chk("sr reset", rdata, {16'h0, SR_RST});
    bfm_u.rd(ADDR_PAGE, rdata);
    chk("page reset", rdata, 32'h0);
    // unmapped place swallows writes and reads as zero
    bfm_u.wr(8'h14, 32'hFFFF_FFFF);
    bfm_u.rd(8'h14, rdata);
    chk("unmapped", rdata, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    for (int i = 0; i < 14; i++) begin
      bfm_u.wr(ADDR_SR, {16'h0, rows[i].sr_in});
      bfm_u.wr(ADDR_PAGE, PAGE_INIT);
      bfm_u.wr(R2, {16'h0, rows[i].rd_in});
      bfm_u.wr(ADDR_SRC, {16'h0, rows[i].src});
      bfm_u.wr(ADDR_INSTR, rows[i].instr);
      nit = (rows[i].instr[31:24] == PFX_CTRL_BYTE) || (rows[i].instr[31:24] == PFX_CTRL_WORD);
      // inhibit rises only when execution ends, after the write returns
      bfm_u.rd(rows[i].chk, rdata);
      chk("inhibit", {31'h0, no_int_trace}, {31'h0, nit});
      chk("result", rdata, rows[i].exp_val);
      bfm_u.rd(ADDR_STATUS, rdata);
      chk("status", {26'h0, rdata[5:0]}, {26'h0, nit, 1'b0, rows[i].flags});
    end
    for (int j = 0; j < 3; j++) begin
      bfm_u.wr(ADDR_SR, 32'h0000_0705);
      bfm_u.wr(ADDR_INSTR, bad[j]);
      bfm_u.rd(ADDR_SR, rdata);
      chk("sr kept", rdata, 32'h0000_0705);
      bfm_u.rd(ADDR_STATUS, rdata);
      chk("illegal", {26'h0, rdata[5:0]}, 32'h0000_0015);
      chk("inhibit end", {31'h0, no_int_trace}, 32'h0);
    end
    // second reset in mid-run puts the registers back
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ready in reset", {31'h0, hreadyout}, 32'h1);
    rst_n <= 1'b1;
    bfm_u.rd(R2, rdata);
    chk("reg reset", rdata, {16'h0, GREG_RST});
    bfm_u.rd(ADDR_SR, rdata);
    chk("sr again", rdata, {16'h0, SR_RST});
    conclude();
  end
endmodule : carry_add_and_logic_unit_tb_top
